// File: verilog/ahpc_defines.svh
// constants for the adc high-pass coefficient register bank
// assumes byte-wide page-one register access with 7-bit offsets
`ifndef AHPC_DEFINES_SVH
`define AHPC_DEFINES_SVH

// ==========================================================
// offsets
`define AHPC_OFS_LN0_HI 7'h41
`define AHPC_OFS_LN0_LO 7'h42
`define AHPC_OFS_LN1_HI 7'h43
`define AHPC_OFS_LN1_LO 7'h44
`define AHPC_OFS_LD1_HI 7'h45
`define AHPC_OFS_LD1_LO 7'h46
`define AHPC_OFS_RN0_HI 7'h47
`define AHPC_OFS_RN0_LO 7'h48
`define AHPC_OFS_RN1_HI 7'h49
`define AHPC_OFS_RN1_LO 7'h4A
`define AHPC_OFS_RD1_HI 7'h4B
`define AHPC_OFS_RD1_LO 7'h4C
`define AHPC_OFS_RSVD_FIRST 7'h4D
`define AHPC_OFS_RSVD_LAST 7'h7F

// ==========================================================
// reset values
`define AHPC_RST_N0_HI 8'h39
`define AHPC_RST_N0_LO 8'h55
`define AHPC_RST_N1_HI 8'hF3
`define AHPC_RST_N1_LO 8'h2D
`define AHPC_RST_D1_HI 8'h53
`define AHPC_RST_D1_LO 8'h7E
`define AHPC_RSVD_VALUE 8'h00
`define AHPC_UNMAPPED_VALUE 8'h00

`endif

// File: verilog/ahpc_pkg.sv
// types for the adc high-pass coefficient register bank
// assumes nothing beyond a systemverilog compiler
package ahpc_pkg;
  typedef logic [7:0] ahpc_byte_t;
  typedef logic signed [15:0] ahpc_coeff_t;
endpackage : ahpc_pkg

// File: verilog/ahpc_coeff_pair.sv
// one coefficient held as an upper and a lower byte register
// assumes a synchronous active-low reset and byte write strobes
module ahpc_coeff_pair
  import ahpc_pkg::*;
#(
  parameter ahpc_byte_t RST_HI = 8'h00,
  parameter ahpc_byte_t RST_LO = 8'h00
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // byte writes
  input wire logic wr_hi,
  input wire logic wr_lo,
  input wire ahpc_byte_t wdata,
  // stored value
  output ahpc_byte_t hi_r,
  output ahpc_byte_t lo_r,
  output ahpc_coeff_t coeff
);
  // ==========================================================
  // byte storage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hi_r <= RST_HI;
    end else if (wr_hi) begin
      hi_r <= wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lo_r <= RST_LO;
    end else if (wr_lo) begin
      lo_r <= wdata;
    end
  end

  // upper byte carries bits 15:8, sign in bit 15
  assign coeff = ahpc_coeff_t'({hi_r, lo_r});
endmodule : ahpc_coeff_pair

// File: verilog/ahpc_regs.sv
// adc high-pass filter coefficient registers, page one 65..127
// assumes the control slave decodes page one and gives a byte bus
// assumes strobes last one cycle and the address is steady with them
//
// Behaviour
// - coefficient is signed 16-bit from two bytes
// - byte registers are full 8-bit read/write
// - left den1 resets to 0x53 / 0x7E
// - right num0 resets to 0x39 / 0x55
// - right num1 resets to 0xF3 / 0x2D
// - right den1 resets like left den1
// - offsets 77..127 read zero, ignore writes
// - left num0 resets to 0x39 / 0x55
// - left num1 resets to 0xF3 / 0x2D
`include "ahpc_defines.svh"

module ahpc_regs
  import ahpc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register access from the control slave
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire ahpc_byte_t reg_wdata,
  output ahpc_byte_t reg_rdata_r,
  output logic reg_hit,
  // coefficients to the filter datapath
  output ahpc_coeff_t left_numerator_tap_zero,
  output ahpc_coeff_t left_numerator_tap_one,
  output ahpc_coeff_t left_denominator_tap_one,
  output ahpc_coeff_t right_numerator_tap_zero,
  output ahpc_coeff_t right_numerator_tap_one,
  output ahpc_coeff_t right_denominator_tap_one
);
  // ==========================================================
  // write decode
  // one strobe per byte register; other offsets select nothing
  logic [11:0] wr_sel;
  // byte views of the six pairs, read back through the mux below
  ahpc_byte_t b_hi [6];
  ahpc_byte_t b_lo [6];

  always_comb begin
    wr_sel = 12'h000;
    if (reg_wr) begin
      if (reg_addr == `AHPC_OFS_LN0_HI) begin
        wr_sel[0] = 1'b1;
      end else if (reg_addr == `AHPC_OFS_LN0_LO) begin
        wr_sel[1] = 1'b1;
      end else if (reg_addr == `AHPC_OFS_LN1_HI) begin
        wr_sel[2] = 1'b1;
      end else if (reg_addr == `AHPC_OFS_LN1_LO) begin
        wr_sel[3] = 1'b1;
      end else if (reg_addr == `AHPC_OFS_LD1_HI) begin
        wr_sel[4] = 1'b1;
      end else if (reg_addr == `AHPC_OFS_LD1_LO) begin
        wr_sel[5] = 1'b1;
      end else if (reg_addr == `AHPC_OFS_RN0_HI) begin
        wr_sel[6] = 1'b1;
      end else if (reg_addr == `AHPC_OFS_RN0_LO) begin
        wr_sel[7] = 1'b1;
      end else if (reg_addr == `AHPC_OFS_RN1_HI) begin
        wr_sel[8] = 1'b1;
      end else if (reg_addr == `AHPC_OFS_RN1_LO) begin
        wr_sel[9] = 1'b1;
      end else if (reg_addr == `AHPC_OFS_RD1_HI) begin
        wr_sel[10] = 1'b1;
      end else if (reg_addr == `AHPC_OFS_RD1_LO) begin
        wr_sel[11] = 1'b1;
      end
      // reserved offsets fall through: writes are dropped
    end
  end

  // ==========================================================
  // coefficient storage
  // one pair module per coefficient keeps each reset value beside its
  // bytes; bytes update one at a time, so a host rewriting a coefficient
  // leaves a mixed value in place between its two byte writes

  // left channel, zeroth numerator tap
  ahpc_coeff_pair #(
    .RST_HI(`AHPC_RST_N0_HI),
    .RST_LO(`AHPC_RST_N0_LO)
  ) u_ln0 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_hi(wr_sel[0]),
    .wr_lo(wr_sel[1]),
    .wdata(reg_wdata),
    .hi_r(b_hi[0]),
    .lo_r(b_lo[0]),
    .coeff(left_numerator_tap_zero)
  );

  // left channel, first numerator tap
  ahpc_coeff_pair #(
    .RST_HI(`AHPC_RST_N1_HI),
    .RST_LO(`AHPC_RST_N1_LO)
  ) u_ln1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_hi(wr_sel[2]),
    .wr_lo(wr_sel[3]),
    .wdata(reg_wdata),
    .hi_r(b_hi[1]),
    .lo_r(b_lo[1]),
    .coeff(left_numerator_tap_one)
  );

  // left channel, first denominator tap
  ahpc_coeff_pair #(
    .RST_HI(`AHPC_RST_D1_HI),
    .RST_LO(`AHPC_RST_D1_LO)
  ) u_ld1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_hi(wr_sel[4]),
    .wr_lo(wr_sel[5]),
    .wdata(reg_wdata),
    .hi_r(b_hi[2]),
    .lo_r(b_lo[2]),
    .coeff(left_denominator_tap_one)
  );

  // right channel, zeroth numerator tap
  ahpc_coeff_pair #(
    .RST_HI(`AHPC_RST_N0_HI),
    .RST_LO(`AHPC_RST_N0_LO)
  ) u_rn0 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_hi(wr_sel[6]),
    .wr_lo(wr_sel[7]),
    .wdata(reg_wdata),
    .hi_r(b_hi[3]),
    .lo_r(b_lo[3]),
    .coeff(right_numerator_tap_zero)
  );

  // right channel, first numerator tap
  ahpc_coeff_pair #(
    .RST_HI(`AHPC_RST_N1_HI),
    .RST_LO(`AHPC_RST_N1_LO)
  ) u_rn1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_hi(wr_sel[8]),
    .wr_lo(wr_sel[9]),
    .wdata(reg_wdata),
    .hi_r(b_hi[4]),
    .lo_r(b_lo[4]),
    .coeff(right_numerator_tap_one)
  );

  // right channel, first denominator tap
  ahpc_coeff_pair #(
    .RST_HI(`AHPC_RST_D1_HI),
    .RST_LO(`AHPC_RST_D1_LO)
  ) u_rd1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_hi(wr_sel[10]),
    .wr_lo(wr_sel[11]),
    .wdata(reg_wdata),
    .hi_r(b_hi[5]),
    .lo_r(b_lo[5]),
    .coeff(right_denominator_tap_one)
  );

  // ==========================================================
  // read path
  // reg_hit tells the slave this bank owns the offset; reserved offsets
  // count as owned and read zero, lower offsets belong to other banks
  ahpc_byte_t rd_nxt;

  always_comb begin
    rd_nxt = `AHPC_UNMAPPED_VALUE;
    reg_hit = 1'b1;
    if (reg_addr == `AHPC_OFS_LN0_HI) begin
      rd_nxt = b_hi[0];
    end else if (reg_addr == `AHPC_OFS_LN0_LO) begin
      rd_nxt = b_lo[0];
    end else if (reg_addr == `AHPC_OFS_LN1_HI) begin
      rd_nxt = b_hi[1];
    end else if (reg_addr == `AHPC_OFS_LN1_LO) begin
      rd_nxt = b_lo[1];
    end else if (reg_addr == `AHPC_OFS_LD1_HI) begin
      rd_nxt = b_hi[2];
    end else if (reg_addr == `AHPC_OFS_LD1_LO) begin
      rd_nxt = b_lo[2];
    end else if (reg_addr == `AHPC_OFS_RN0_HI) begin
      rd_nxt = b_hi[3];
    end else if (reg_addr == `AHPC_OFS_RN0_LO) begin
      rd_nxt = b_lo[3];
    end else if (reg_addr == `AHPC_OFS_RN1_HI) begin
      rd_nxt = b_hi[4];
    end else if (reg_addr == `AHPC_OFS_RN1_LO) begin
      rd_nxt = b_lo[4];
    end else if (reg_addr == `AHPC_OFS_RD1_HI) begin
      rd_nxt = b_hi[5];
    end else if (reg_addr == `AHPC_OFS_RD1_LO) begin
      rd_nxt = b_lo[5];
    end else if (reg_addr >= `AHPC_OFS_RSVD_FIRST) begin
      rd_nxt = `AHPC_RSVD_VALUE;
    end else begin
      // offsets below 65 belong to other banks of the page
      reg_hit = 1'b0;
    end
  end

  // ==========================================================
  // read data register
  // read data held until the next read so the slave can shift it out
  // before the first read the register holds zero, as an unowned offset would read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata_r <= `AHPC_UNMAPPED_VALUE;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_nxt;
    end
  end
endmodule : ahpc_regs

// File: testbench/ahpc_regs_props.sv
// assertions on the coefficient bank ports
// assumes ahpc_regs with a synchronous active-low reset
module ahpc_regs_props
  import ahpc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire ahpc_byte_t reg_wdata,
  input wire ahpc_byte_t reg_rdata_r,
  // coefficients
  input wire ahpc_coeff_t left_numerator_tap_zero,
  input wire ahpc_coeff_t left_numerator_tap_one,
  input wire ahpc_coeff_t left_denominator_tap_one,
  input wire ahpc_coeff_t right_numerator_tap_zero,
  input wire ahpc_coeff_t right_numerator_tap_one,
  input wire ahpc_coeff_t right_denominator_tap_one
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  // ======
  // reset values, no disable: they check reset itself
  ln0_rst_a: assert property (
    !rst_n |=> left_numerator_tap_zero == 16'h3955) else $error("ln0 reset");
  ln1_rst_a: assert property (
    !rst_n |=> left_numerator_tap_one == 16'hF32D) else $error("ln1 reset");
  ld1_rst_a: assert property (
    !rst_n |=> left_denominator_tap_one == 16'h537E) else $error("ld1 reset");
  rn0_rst_a: assert property (
    !rst_n |=> right_numerator_tap_zero == 16'h3955) else $error("rn0 reset");
  rn1_rst_a: assert property (
    !rst_n |=> right_numerator_tap_one == 16'hF32D) else $error("rn1 reset");
  rd1_rst_a: assert property (
    !rst_n |=> right_denominator_tap_one == 16'h537E) else $error("rd1 reset");
  // ======
  // accesses
  rsvd_zero_a: assert property (disable iff (!rst_n)
    reg_rd && reg_addr > 7'h4C |=> reg_rdata_r == 8'h00) else $error("rsvd");
  hi_write_a: assert property (disable iff (!rst_n)
    reg_wr && reg_addr == 7'h49 |=> right_numerator_tap_one[15:8]
      == $past(reg_wdata)) else $error("upper byte write");
  lo_write_a: assert property (disable iff (!rst_n)
    reg_wr && reg_addr == 7'h46 |=> left_denominator_tap_one[7:0]
      == $past(reg_wdata)) else $error("lower byte write");
  cover property (reg_wr && reg_addr == 7'h49);
  cover property (reg_rd && reg_addr > 7'h4C);
  cover property (rst_n && !$past(rst_n));
endmodule : ahpc_regs_props

bind ahpc_regs ahpc_regs_props i_props (.*);

// File: testbench/ahpc_host.sv
// control-bus master standing in for the host processor
// assumes the bank takes one-cycle strobes on sys_clk
module ahpc_host
  import ahpc_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // register requests
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [6:0] reg_addr = 7'h00,
  output ahpc_byte_t reg_wdata = 8'h00
);
  timeunit 1ns;
  timeprecision 100ps;
  // every setting goes through this byte access
  task automatic xfer(logic w, logic r, logic [6:0] a, ahpc_byte_t d);
    @(posedge sys_clk);
    #1;
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // released lines must not keep the old value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : xfer
endmodule : ahpc_host

// File: testbench/tb.sv
// self-checking bench for the coefficient bank
// assumes ahpc_host drives the bus and the checker is bound
module tb
  import ahpc_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk;
  logic rst_n;
  logic reg_wr, reg_rd, reg_hit;
  logic [6:0] reg_addr;
  ahpc_byte_t reg_wdata, reg_rdata_r;
  ahpc_coeff_t left_numerator_tap_zero, left_numerator_tap_one;
  ahpc_coeff_t left_denominator_tap_one, right_numerator_tap_zero;
  ahpc_coeff_t right_numerator_tap_one, right_denominator_tap_one;
  ahpc_coeff_t co [6];
  int exp_b [128];
  int num_errors, checked, cycles;
  ahpc_regs i_dut (.*);
  ahpc_host i_host (.*);
  assign co = '{left_numerator_tap_zero, left_numerator_tap_one,
    left_denominator_tap_one, right_numerator_tap_zero,
    right_numerator_tap_one, right_denominator_tap_one};
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("wrong value at %0t: timeout", $time);
      test_done();
    end
  end
  task automatic cmp8(ahpc_byte_t got, int want);
    checked++;
    if (got !== 8'(want)) begin
      num_errors++;
      $display("wrong value at %0t: byte %h not %h", $time, got, 8'(want));
    end
  endtask : cmp8
  task automatic cmp16(ahpc_coeff_t got, int want);
    checked++;
    if (got !== 16'(want)) begin
      num_errors++;
      $display("wrong value at %0t: coeff %h not %h", $time, got, 16'(want));
    end
  endtask : cmp16
  task automatic cmp_hit(logic got, logic want);
    checked++;
    if (got !== want) begin
      num_errors++;
      $display("wrong value at %0t: hit %b not %b", $time, got, want);
    end
  endtask : cmp_hit
  // ownership flag follows the address, so look at the taking edge
  always @(posedge sys_clk) begin
    if (rst_n && (reg_wr || reg_rd)) begin
      cmp_hit(reg_hit, reg_addr >= 7'h41);
    end
  end
  task automatic model_reset();
    int def [3] = '{16'h3955, 16'hF32D, 16'h537E};
    exp_b = '{default: 0};
    for (int i = 0; i < 6; i++) begin
      exp_b[65 + 2 * i] = def[i % 3] >> 8;
      exp_b[66 + 2 * i] = def[i % 3] & 16'h00FF;
    end
  endtask : model_reset
  task automatic check_all(string name);
    for (int i = 0; i < 6; i++) begin
      cmp16(co[i], exp_b[65 + 2 * i] * 256 + exp_b[66 + 2 * i]);
    end
    for (int a = 64; a < 128; a++) begin
      i_host.xfer(1'b0, 1'b1, 7'(a), 8'h00);
      cmp8(reg_rdata_r, exp_b[a]);
    end
    $display("test %s done", name);
  endtask : check_all
  initial begin
    int a;
    int d;
    int k;
    num_errors = 0;
    checked = 0;
    cycles = 0;
    rst_n = 1'b0;
    void'($urandom(77469));
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    model_reset();
    check_all("defaults");
    for (int n = 0; n < 24; n++) begin
      a = 65 + n % 12;
      d = $urandom % 256;
      i_host.xfer(1'b1, 1'b0, 7'(a), 8'(d));
      exp_b[a] = d;
      k = (a - 65) / 2;
      cmp16(co[k], exp_b[65 + 2 * k] * 256 + exp_b[66 + 2 * k]);
    end
    check_all("random writes");
    // the host keeps off reserved offsets; writes meant for other banks
    // of the page must leave this bank untouched
    for (a = 4; a < 55; a += 10) begin
      i_host.xfer(1'b1, 1'b0, 7'(a), 8'($urandom));
    end
    check_all("other banks");
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    model_reset();
    check_all("second reset");
    test_done();
  end
endmodule : tb
